/* File: inc/lpw_pkg.sv */
package lpw_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_PWR_CTRL = 8'h00;
  localparam logic [7:0] OFS_PCI_PMCS = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_NODE_LO = 8'h0c;
  localparam logic [7:0] OFS_NODE_HI = 8'h10;
  // Power saving control fields
  localparam int PSC_OVERRIDE = 0;
  localparam int PSC_RST10 = 1;
  localparam int PSC_RST100 = 2;
  localparam int PSC_POWERDOWN_10M_CORE = 3;
  localparam int PSC_POWERDOWN_100M_CORE = 4;
  localparam int PSC_POWERDOWN_10M_DRIVERS = 5;
  localparam int PSC_POWERDOWN_100M_DRIVERS = 6;
  localparam int PSC_TXCLK = 7;
  localparam int PSC_RXCLK = 8;
  localparam int PSC_AUTO = 9;
  localparam int PSC_W = 10;
  localparam logic [9:0] PSC_RESET = 10'h000;
  // PCI power control/status fields
  localparam int PMCS_STATE_LSB = 0;
  localparam int PMCS_EVT_EN = 8;
  localparam int PMCS_EVT_STAT = 15;
  // Status register wake flag
  localparam int STAT_WAKE = 28;
  // Power states in the two-bit field
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D1 = 2'h1;
  localparam logic [1:0] PS_D2 = 2'h2;
  localparam logic [1:0] PS_D3 = 2'h3;
  // Wake pattern shape
  localparam logic [7:0] SYNC_BYTE = 8'hff;
  localparam logic [2:0] SYNC_LEN = 3'h6;
  localparam logic [2:0] ADDR_LAST = 3'h5;
  localparam logic [3:0] COPY_LAST = 4'hf;
  // Serial memory words holding the node identity
  localparam logic [7:0] EE_ID_BASE = 8'h00;
  localparam logic [1:0] EE_ID_WORDS = 2'h3;
endpackage

/* File: verilog/lpw_power_wake.sv */
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module lpw_power_wake (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_sof_i,
  input wire logic rx_eof_i,
  input wire logic rx_da_match_i,
  input wire logic wake_frame_hit_i,
  input wire logic link_up_i,
  input wire logic pci_rst_n_i,
  input wire logic ee_ack_i,
  input wire logic [15:0] ee_data_i,
  output logic ee_req_o,
  output logic [7:0] ee_addr_o,
  output logic reset_10m_analog_o,
  output logic reset_100m_analog_o,
  output logic powerdown_10m_core_o,
  output logic powerdown_100m_core_o,
  output logic powerdown_10m_drivers_o,
  output logic powerdown_100m_drivers_o,
  output logic tx_clock_run_o,
  output logic rx_clock_run_o,
  output logic rx_store_block_o,
  output logic rx_monitor_on_o,
  output logic int_n_o,
  output logic pm_event_pin_n_o,
  output logic lan_wake_out_o
);
  // Loader states
  typedef enum logic [1:0] {LD_REQ, LD_WAIT, LD_DONE} lpw_load_e;

  // Reset release synchroniser
  logic rst_meta;
  logic rst_n;
  // Pin synchronisers and link history
  logic link_meta, link_sync, link_prev;
  logic prst_meta, prst_sync;
  // Software state
  logic [9:0] power_saving_control, next_psc;
  logic [1:0] pstate, next_pstate;
  logic pm_event_enable, next_pme_en;
  logic pme_status, next_pme_status;
  logic wakeup_int_flag, next_wake_flag;
  logic [31:0] next_rdata;
  // Node identity, six bytes, first on the wire at index 0
  logic [7:0] node_b [6];
  logic [7:0] next_node_b [6];
  lpw_load_e ld_state, next_ld_state;
  logic [1:0] ld_word, next_ld_word;
  // Detector state
  logic [2:0] ff_cnt, next_ff_cnt;
  logic in_addr, next_in_addr;
  logic [2:0] byte_idx, next_byte_idx;
  logic [3:0] copy_cnt, next_copy_cnt;
  logic found, next_found;
  logic found_now;
  // Event terms
  logic asleep, armed;
  logic magic_evt, frame_evt, link_evt, wake_evt;
  logic wr_psc, wr_pmcs, wr_stat;
  logic next_rst10, next_rst100, next_lan_wake;
  logic next_powerdown_10m_core, next_powerdown_100m_core, next_powerdown_10m_drivers, next_powerdown_100m_drivers;
  logic next_txclk, next_rxclk;

  // Reset assert is immediate, release waits two edges
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Link and PCI reset pins are foreign, so two flops before use
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      link_meta <= 1'b0;
      link_sync <= 1'b0;
      link_prev <= 1'b0;
      prst_meta <= 1'b0;
      prst_sync <= 1'b0;
    end else begin
      link_meta <= link_up_i;
      link_sync <= link_meta;
      link_prev <= link_sync;
      prst_meta <= pci_rst_n_i;
      prst_sync <= prst_meta;
    end
  end

  // clock_i is the standby clock, running in every state
  assign asleep = (pstate != lpw_pkg::PS_D0);
  // events only armed once enable and state are written
  assign armed = asleep && pm_event_enable;
  assign wr_psc = reg_wr_i && (reg_addr_i == lpw_pkg::OFS_PWR_CTRL);
  assign wr_pmcs = reg_wr_i && (reg_addr_i == lpw_pkg::OFS_PCI_PMCS);
  assign wr_stat = reg_wr_i && (reg_addr_i == lpw_pkg::OFS_STATUS);

  // Node identity loader: reads three words after reset
  always_comb begin
    next_ld_state = ld_state;
    next_ld_word = ld_word;
    next_node_b = node_b;
    unique case (ld_state)
      LD_REQ: begin
        next_ld_state = LD_WAIT;
      end
      LD_WAIT: begin
        // identity captured with no host programming
        if (ee_ack_i) begin
          next_node_b[{ld_word, 1'b0}] = ee_data_i[7:0];
          next_node_b[{ld_word, 1'b1}] = ee_data_i[15:8];
          next_ld_word = ld_word + 2'h1;
          if (ld_word == lpw_pkg::EE_ID_WORDS - 2'h1) begin
            next_ld_state = LD_DONE;
          end else begin
            next_ld_state = LD_REQ;
          end
        end
      end
      LD_DONE: begin
        next_ld_state = LD_DONE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ld_state <= LD_REQ;
      ld_word <= 2'h0;
      node_b <= '{default: 8'h00};
      ee_req_o <= 1'b0;
      ee_addr_o <= 8'h00;
    end else begin
      ld_state <= next_ld_state;
      ld_word <= next_ld_word;
      node_b <= next_node_b;
      // Request stays up until the word is acknowledged
      ee_req_o <= (next_ld_state == LD_WAIT);
      ee_addr_o <= lpw_pkg::EE_ID_BASE + {6'h00, next_ld_word};
    end
  end

  // Pattern search: sync run then sixteen address copies
  always_comb begin
    next_ff_cnt = ff_cnt;
    next_in_addr = in_addr;
    next_byte_idx = byte_idx;
    next_copy_cnt = copy_cnt;
    next_found = found;
    found_now = found;
    if (!asleep) begin
      // held clear in the fully-on state
      next_ff_cnt = 3'h0;
      next_in_addr = 1'b0;
      next_byte_idx = 3'h0;
      next_copy_cnt = 4'h0;
      next_found = 1'b0;
      found_now = 1'b0;
    end else if (rx_valid_i) begin
      if (rx_sof_i) begin
        // New frame: forget anything from the last one
        next_ff_cnt = 3'h0;
        next_in_addr = 1'b0;
        next_found = 1'b0;
        found_now = 1'b0;
      end
      if (!next_in_addr) begin
        // address copies only after six sync bytes
        if (next_ff_cnt == lpw_pkg::SYNC_LEN && rx_data_i == node_b[0]) begin
          next_in_addr = 1'b1;
          next_byte_idx = 3'h1;
          next_copy_cnt = 4'h0;
        end else if (rx_data_i == lpw_pkg::SYNC_BYTE) begin
          // Longer sync runs are fine, counter saturates
          if (next_ff_cnt != lpw_pkg::SYNC_LEN) begin
            next_ff_cnt = next_ff_cnt + 3'h1;
          end
        end else begin
          next_ff_cnt = 3'h0;
        end
      // copies must be back to back, any break restarts
      end else if (rx_data_i == node_b[byte_idx]) begin
        if (byte_idx == lpw_pkg::ADDR_LAST) begin
          next_byte_idx = 3'h0;
          if (copy_cnt == lpw_pkg::COPY_LAST) begin
            next_found = 1'b1;
            found_now = 1'b1;
            next_in_addr = 1'b0;
            next_ff_cnt = 3'h0;
          end else begin
            next_copy_cnt = copy_cnt + 4'h1;
          end
        end else begin
          next_byte_idx = byte_idx + 3'h1;
        end
      end else begin
        // Broken run; an FF byte may start a fresh sync
        next_in_addr = 1'b0;
        next_ff_cnt = (rx_data_i == lpw_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ff_cnt <= 3'h0;
      in_addr <= 1'b0;
      byte_idx <= 3'h0;
      copy_cnt <= 4'h0;
      found <= 1'b0;
    end else begin
      ff_cnt <= next_ff_cnt;
      in_addr <= next_in_addr;
      byte_idx <= next_byte_idx;
      copy_cnt <= next_copy_cnt;
      found <= next_found;
    end
  end

  // pattern, address match, enable and sleep all needed
  // no frame check status enters this decision
  assign magic_evt = armed && rx_valid_i && rx_eof_i && rx_da_match_i &&
                     found_now;
  // Frame filters are qualified upstream; gate with sleep and enable
  assign frame_evt = armed && wake_frame_hit_i;
  // cable reconnect seen as rising synchronised link
  assign link_evt = armed && link_sync && !link_prev;
  // any of the three kinds is a wake
  assign wake_evt = magic_evt || frame_evt || link_evt;

  // Register file next values
  always_comb begin
    next_psc = power_saving_control;
    next_pstate = pstate;
    next_pme_en = pm_event_enable;
    next_pme_status = pme_status;
    next_wake_flag = wakeup_int_flag;
    next_rdata = 32'h0000_0000;
    if (wr_psc) begin
      next_psc = reg_wdata_i[lpw_pkg::PSC_W-1:0];
    end
    if (wr_pmcs) begin
      next_pstate = reg_wdata_i[lpw_pkg::PMCS_STATE_LSB +: 2];
      next_pme_en = reg_wdata_i[lpw_pkg::PMCS_EVT_EN];
      // Write one to clear
      if (reg_wdata_i[lpw_pkg::PMCS_EVT_STAT]) begin
        next_pme_status = 1'b0;
      end
    end
    if (wr_stat && reg_wdata_i[lpw_pkg::STAT_WAKE]) begin
      next_wake_flag = 1'b0;
    end
    // event status set, winning over a clear
    // flags stay until software clears them
    if (wake_evt) begin
      next_pme_status = 1'b1;
    end
    // wake flag set, winning over a clear
    if (wake_evt) begin
      next_wake_flag = 1'b1;
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        lpw_pkg::OFS_PWR_CTRL: begin
          next_rdata[lpw_pkg::PSC_W-1:0] = power_saving_control;
        end
        lpw_pkg::OFS_PCI_PMCS: begin
          next_rdata[lpw_pkg::PMCS_STATE_LSB +: 2] = pstate;
          next_rdata[lpw_pkg::PMCS_EVT_EN] = pm_event_enable;
          next_rdata[lpw_pkg::PMCS_EVT_STAT] = pme_status;
        end
        lpw_pkg::OFS_STATUS: begin
          next_rdata[lpw_pkg::STAT_WAKE] = wakeup_int_flag;
        end
        lpw_pkg::OFS_NODE_LO: begin
          next_rdata = {node_b[3], node_b[2], node_b[1], node_b[0]};
        end
        lpw_pkg::OFS_NODE_HI: begin
          next_rdata[15:0] = {node_b[5], node_b[4]};
        end
        default: begin
          // Unmapped addresses read as zero
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      power_saving_control <= lpw_pkg::PSC_RESET;
      pstate <= lpw_pkg::PS_D0;
      pm_event_enable <= 1'b0;
      pme_status <= 1'b0;
      wakeup_int_flag <= 1'b0;
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      power_saving_control <= next_psc;
      pstate <= next_pstate;
      pm_event_enable <= next_pme_en;
      pme_status <= next_pme_status;
      wakeup_int_flag <= next_wake_flag;
      reg_rdata_o <= next_rdata;
    end
  end

  // Power controls: manual beats automatic, which beats normal
  always_comb begin
    next_powerdown_10m_core = 1'b0;
    next_powerdown_100m_core = 1'b0;
    next_powerdown_10m_drivers = 1'b0;
    next_powerdown_100m_drivers = 1'b0;
    next_txclk = 1'b1;
    next_rxclk = 1'b1;
    // pulse on a 0 to 1 write of a reset bit, override set before and in the write
    next_rst10 = wr_psc && power_saving_control[lpw_pkg::PSC_OVERRIDE] &&
                 reg_wdata_i[lpw_pkg::PSC_OVERRIDE] &&
                 !power_saving_control[lpw_pkg::PSC_RST10] &&
                 reg_wdata_i[lpw_pkg::PSC_RST10];
    next_rst100 = wr_psc && power_saving_control[lpw_pkg::PSC_OVERRIDE] &&
                  reg_wdata_i[lpw_pkg::PSC_OVERRIDE] &&
                  !power_saving_control[lpw_pkg::PSC_RST100] &&
                  reg_wdata_i[lpw_pkg::PSC_RST100];
    // manual bits only count with override set
    if (power_saving_control[lpw_pkg::PSC_OVERRIDE]) begin
      next_powerdown_10m_core = power_saving_control[lpw_pkg::PSC_POWERDOWN_10M_CORE];
      next_powerdown_100m_core = power_saving_control[lpw_pkg::PSC_POWERDOWN_100M_CORE];
      next_powerdown_10m_drivers = power_saving_control[lpw_pkg::PSC_POWERDOWN_10M_DRIVERS];
      next_powerdown_100m_drivers = power_saving_control[lpw_pkg::PSC_POWERDOWN_100M_DRIVERS];
      // a zero bit stops the clock
      next_txclk = power_saving_control[lpw_pkg::PSC_TXCLK];
      next_rxclk = power_saving_control[lpw_pkg::PSC_RXCLK];
    end else if (power_saving_control[lpw_pkg::PSC_AUTO]) begin
      // receive clock and cores kept up for monitoring
      next_txclk = (pstate == lpw_pkg::PS_D0);
      next_powerdown_10m_drivers = (pstate == lpw_pkg::PS_D2) || (pstate == lpw_pkg::PS_D3);
      next_powerdown_100m_drivers = next_powerdown_10m_drivers;
    end
    // lan wake held until synced PCI reset
    next_lan_wake = lan_wake_out_o;
    if (!prst_sync) begin
      next_lan_wake = 1'b0;
    end
    // lan wake set on any wake, set wins
    if (wake_evt) begin
      next_lan_wake = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      reset_10m_analog_o <= 1'b0;
      reset_100m_analog_o <= 1'b0;
      powerdown_10m_core_o <= 1'b0;
      powerdown_100m_core_o <= 1'b0;
      powerdown_10m_drivers_o <= 1'b0;
      powerdown_100m_drivers_o <= 1'b0;
      tx_clock_run_o <= 1'b1;
      rx_clock_run_o <= 1'b1;
      rx_store_block_o <= 1'b0;
      rx_monitor_on_o <= 1'b1;
      int_n_o <= 1'b1;
      pm_event_pin_n_o <= 1'b1;
      lan_wake_out_o <= 1'b0;
    end else begin
      reset_10m_analog_o <= next_rst10;
      reset_100m_analog_o <= next_rst100;
      powerdown_10m_core_o <= next_powerdown_10m_core;
      powerdown_100m_core_o <= next_powerdown_100m_core;
      powerdown_10m_drivers_o <= next_powerdown_10m_drivers;
      powerdown_100m_drivers_o <= next_powerdown_100m_drivers;
      tx_clock_run_o <= next_txclk;
      rx_clock_run_o <= next_rxclk;
      // sleeping frames are scanned, not stored
      rx_store_block_o <= asleep;
      rx_monitor_on_o <= asleep || next_rxclk;
      // interrupt low while flag and enable
      int_n_o <= !(wakeup_int_flag && pm_event_enable);
      // event pin low while status and enable
      pm_event_pin_n_o <= !(pme_status && pm_event_enable);
      lan_wake_out_o <= next_lan_wake;
    end
  end

  // Checks on the logic above
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  sequence s_ovr_low_bit1;
    wr_psc && reg_wdata_i[0] && !reg_wdata_i[1];
  endsequence
  sequence s_ovr_high_bit1;
    wr_psc && reg_wdata_i[0] && reg_wdata_i[1];
  endsequence

  chk_override_gate: assert property (
    !power_saving_control[0] && !power_saving_control[9] |=>
      !powerdown_10m_core_o && !powerdown_100m_drivers_o && tx_clock_run_o)
    else $error("manual bits acted without override");
  chk_reset_pulse: assert property (
    s_ovr_low_bit1 ##1 s_ovr_high_bit1 |=>
      reset_10m_analog_o ##1 !reset_10m_analog_o)
    else $error("10m analog reset pulse missing");
  chk_core_down: assert property (
    power_saving_control[0] && power_saving_control[4] |=>
      powerdown_100m_core_o && !$past(power_saving_control[6]) ==
      !powerdown_100m_drivers_o)
    else $error("core power down wrong");
  chk_driver_down: assert property (
    power_saving_control[0] && power_saving_control[5] |=>
      powerdown_10m_drivers_o)
    else $error("10m drivers not powered down");
  chk_clock_stop: assert property (
    power_saving_control[0] && !power_saving_control[8] |=> !rx_clock_run_o)
    else $error("receive clock not stopped");
  chk_auto_grade: assert property (
    !power_saving_control[0] && power_saving_control[9] &&
      pstate == lpw_pkg::PS_D1 |=> !tx_clock_run_o && rx_clock_run_o)
    else $error("auto saving wrong in D1");
  chk_d0_idle: assert property (
    !asleep |=> !found && !in_addr && ff_cnt == 3'h0)
    else $error("detector active in D0");
  chk_status_set: assert property (
    wake_evt |=> pme_status && wakeup_int_flag ##1 !pm_event_pin_n_o ||
      !pm_event_enable)
    else $error("wake status not raised");
  chk_int_line: assert property (
    wakeup_int_flag && pm_event_enable |=> !int_n_o)
    else $error("interrupt line not low");
  chk_lan_hold: assert property (
    lan_wake_out_o && prst_sync |=> lan_wake_out_o)
    else $error("lan wake dropped without PCI reset");
  chk_store_block: assert property (
    asleep [*2] |=> rx_store_block_o)
    else $error("frames stored while asleep");
endmodule

/* File: sim/lpw_eeprom_model.sv */
`timescale 1ns/1ns
// Serial memory stand-in that serves the node identity words
module lpw_eeprom_model #(
  parameter logic [47:0] NODE_ID = 48'h665544332211
) (
  input wire logic clock_i,
  input wire logic ee_req_i,
  input wire logic [7:0] ee_addr_i,
  output logic ee_ack_o,
  output logic [15:0] ee_data_o
);
  logic ack_q = 1'b0; // One-cycle answer strobe
  logic [15:0] data_q = 16'h5a5a; // Word lines, moving while idle
  logic [1:0] wait_cnt = 2'h0; // Stall counter for slow answers
  assign ee_ack_o = ack_q;
  assign ee_data_o = data_q;
  // Odd words answer at once, even words stall so both speeds are seen
  always @(posedge clock_i) begin
    ack_q <= 1'b0;
    if (ee_req_i && !ack_q) begin
      if (ee_addr_i[0] || wait_cnt == 2'h3) begin
        ack_q <= 1'b1;
        data_q <= NODE_ID[ee_addr_i[1:0] * 16 +: 16];
        wait_cnt <= 2'h0;
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end else begin
      // Released lines never hold the last word
      data_q <= ~data_q;
    end
  end
endmodule

/* File: sim/lpw_power_wake_bench.sv */
`timescale 1ns/1ns
module lpw_power_wake_bench;
  localparam logic [47:0] NODE = 48'h665544332211;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic sof = 1'b0;
  logic eof = 1'b0;
  logic da_match = 1'b0;
  logic frame_hit = 1'b0;
  logic link_up = 1'b0;
  logic pci_rst_n = 1'b1;
  logic ee_ack;
  logic [15:0] ee_data;
  logic ee_req;
  logic [7:0] ee_addr;
  logic [1:0] pulse; // Analog reset pulses, 100M in bit 1
  logic [5:0] pwr; // Clock runs over driver and core powerdowns
  logic [2:0] wk; // Lan wake, event pin, interrupt line
  logic [1:0] rxs; // Store block, monitor on
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int hits [2];

  lpw_power_wake i_lpw_power_wake (
    .clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_sof_i(sof),
    .rx_eof_i(eof), .rx_da_match_i(da_match),
    .wake_frame_hit_i(frame_hit), .link_up_i(link_up),
    .pci_rst_n_i(pci_rst_n), .ee_ack_i(ee_ack), .ee_data_i(ee_data),
    .ee_req_o(ee_req), .ee_addr_o(ee_addr),
    .reset_10m_analog_o(pulse[0]), .reset_100m_analog_o(pulse[1]),
    .powerdown_10m_core_o(pwr[0]), .powerdown_100m_core_o(pwr[1]),
    .powerdown_10m_drivers_o(pwr[2]), .powerdown_100m_drivers_o(pwr[3]),
    .tx_clock_run_o(pwr[4]), .rx_clock_run_o(pwr[5]),
    .rx_store_block_o(rxs[1]), .rx_monitor_on_o(rxs[0]),
    .int_n_o(wk[0]), .pm_event_pin_n_o(wk[1]), .lan_wake_out_o(wk[2])
  );

  lpw_eeprom_model #(.NODE_ID(NODE)) i_lpw_eeprom_model (
    .clock_i(clock_i), .ee_req_i(ee_req), .ee_addr_i(ee_addr),
    .ee_ack_o(ee_ack), .ee_data_o(ee_data)
  );

  // Free-running 100 MHz clock
  always #5 clock_i = ~clock_i;

  task automatic finish_test();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard, far above the length of the whole sequence
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
  endtask

  // One-cycle read, data judged in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // Let registered outputs and pins land
  task automatic settle();
    repeat (3) @(posedge clock_i);
    #1;
  endtask

  // Frame with a stray node byte ahead of the sync run and a bad CRC tail
  task automatic send(input int nsync, input int ncopy, input logic dam);
    logic [7:0] q[$];
    q = '{8'h00, 8'h5a, 8'h11};
    repeat (nsync) q.push_back(8'hff);
    repeat (ncopy) for (int k = 0; k < 6; k++) q.push_back(NODE[8*k +: 8]);
    q.push_back(8'h3c);
    foreach (q[i]) begin
      @(posedge clock_i);
      rx_valid <= 1'b1;
      rx_data <= q[i];
      sof <= (i == 0);
      eof <= (i == q.size() - 1);
      da_match <= dam;
    end
    @(posedge clock_i);
    rx_valid <= 1'b0;
    eof <= 1'b0;
    settle();
  endtask

  // Idle levels, register defaults and the loaded identity
  task automatic t_reset();
    #1;
    chk(pwr, 6'h30);
    chk({wk, rxs}, 5'h0d);
    rd(lpw_pkg::OFS_PWR_CTRL, 32'h0);
    rd(lpw_pkg::OFS_NODE_LO, 32'h44332211);
    rd(lpw_pkg::OFS_NODE_HI, 32'h00006655);
    rd(8'h14, 32'h0);
  endtask

  // Manual bits ignored until override, then drive the outputs
  task automatic t_manual();
    wr(lpw_pkg::OFS_PWR_CTRL, 32'h078);
    settle();
    chk(pwr, 6'h30);
    wr(lpw_pkg::OFS_PWR_CTRL, 32'h079);
    settle();
    chk(pwr, 6'h0f);
    rd(lpw_pkg::OFS_PWR_CTRL, 32'h079);
    // Back-to-back writes: reset bits cleared, then set, strobe held up
    @(posedge clock_i);
    addr <= lpw_pkg::OFS_PWR_CTRL;
    wdata <= 32'h001;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wdata <= 32'h007;
    @(posedge clock_i);
    wr_s <= 1'b0;
    hits = '{0, 0};
    repeat (3) begin
      #1;
      hits[0] += int'(pulse[0] === 1'b1);
      hits[1] += int'(pulse[1] === 1'b1);
      @(posedge clock_i);
    end
    chk(hits[0], 1);
    chk(hits[1], 1);
    wr(lpw_pkg::OFS_PWR_CTRL, 32'h0);
  endtask

  // Automatic saving graded by power state
  task automatic t_auto();
    wr(lpw_pkg::OFS_PWR_CTRL, 32'h200);
    wr(lpw_pkg::OFS_PCI_PMCS, 32'h101);
    settle();
    chk(pwr, 6'h20);
    wr(lpw_pkg::OFS_PCI_PMCS, 32'h103);
    settle();
    chk(pwr, 6'h2c);
    wr(lpw_pkg::OFS_PCI_PMCS, 32'h102);
    settle();
    chk(pwr, 6'h2c);
    wr(lpw_pkg::OFS_PCI_PMCS, 32'h100);
    wr(lpw_pkg::OFS_PWR_CTRL, 32'h0);
    settle();
    chk(pwr, 6'h30);
  endtask

  // Clear both flags, rewriting state and enable from pmcs
  task automatic clear_flags(input logic [31:0] pmcs);
    wr(lpw_pkg::OFS_PCI_PMCS, pmcs | 32'h8000);
    wr(lpw_pkg::OFS_STATUS, 32'h10000000);
    settle();
  endtask

  task automatic pci_reset();
    @(posedge clock_i);
    pci_rst_n <= 1'b0;
    settle();
    chk(wk[2], 1'b0);
    @(posedge clock_i);
    pci_rst_n <= 1'b1;
  endtask

  // Wake packet: refused in D0 and on near misses, then taken
  task automatic t_packet();
    send(6, 16, 1'b1);
    chk({wk, rxs}, 5'h0d);
    wr(lpw_pkg::OFS_PCI_PMCS, 32'h103);
    settle();
    chk(rxs, 2'h3);
    send(5, 16, 1'b1);
    send(6, 16, 1'b0);
    send(6, 15, 1'b1);
    chk(wk, 3'h3);
    send(6, 16, 1'b1);
    chk(wk, 3'h4);
    rd(lpw_pkg::OFS_PCI_PMCS, 32'h8103);
    rd(lpw_pkg::OFS_STATUS, 32'h10000000);
    settle();
    chk(wk, 3'h4);
    clear_flags(32'h103);
    chk(wk, 3'h7);
    rd(lpw_pkg::OFS_STATUS, 32'h0);
    pci_reset();
  endtask

  // Link reconnect and filter hit while armed and asleep, then a filter hit with the enable clear
  task automatic t_events();
    wr(lpw_pkg::OFS_PCI_PMCS, 32'h102);
    link_up <= 1'b1;
    repeat (4) @(posedge clock_i);
    settle();
    chk(wk, 3'h4);
    clear_flags(32'h102);
    pci_reset();
    @(posedge clock_i);
    frame_hit <= 1'b1;
    @(posedge clock_i);
    frame_hit <= 1'b0;
    settle();
    chk(wk, 3'h4);
    rd(lpw_pkg::OFS_PCI_PMCS, 32'h8102);
    clear_flags(32'h002);
    @(posedge clock_i);
    frame_hit <= 1'b1;
    @(posedge clock_i);
    frame_hit <= 1'b0;
    settle();
    chk(wk, 3'h7);
    // Pins are gated by the enable too, so the flags must be read
    rd(lpw_pkg::OFS_PCI_PMCS, 32'h00000002);
    rd(lpw_pkg::OFS_STATUS, 32'h0);
  endtask

  // Reset, let the identity load, then run each scenario
  initial begin
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (40) @(posedge clock_i);
    t_reset();
    t_manual();
    t_auto();
    t_packet();
    t_events();
    finish_test();
  end
endmodule
